// file: tb/tb.sv
// Purpose: Self-checking bench for the 8-bit timer
// Assumes: One aclk cycle is one instruction cycle
// Notes: Counts judged as differences between timed reads
`timescale 1ns/1ps
module tb;
	localparam logic [11:0] A_CNT = tmr8_pkg::TMR8_ADDR_COUNT;
	localparam logic [11:0] A_INT = tmr8_pkg::TMR8_ADDR_INTCTL;
	localparam logic [11:0] A_OPT = tmr8_pkg::TMR8_ADDR_OPTION;
	localparam logic [11:0] A_CTL = tmr8_pkg::TMR8_ADDR_CTRL;
	// Option, sleep, cycles between reads, count advance
	localparam logic [32:0] ROWS [12] = '{
		{8'h08, 1'h0, 16'h14, 8'h14}, {8'h0F, 1'h0, 16'h14, 8'h14}, {8'h28, 1'h0, 16'h14, 8'h00},
		{8'h08, 1'h1, 16'h14, 8'h00}, {8'h00, 1'h0, 16'h10, 8'h08}, {8'h01, 1'h0, 16'h10, 8'h04},
		{8'h02, 1'h0, 16'h10, 8'h02}, {8'h03, 1'h0, 16'h20, 8'h02}, {8'h04, 1'h0, 16'h40, 8'h02},
		{8'h05, 1'h0, 16'h80, 8'h02}, {8'h06, 1'h0, 16'h100, 8'h02}, {8'h07, 1'h0, 16'h200, 8'h02}};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0;
	logic [11:0] s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, watchdog_tick = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic external_count_pin, watchdog_post_tick, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rdat, c0;
	int cyc = 0, ts, ta, tw, err_count = 0, num_checks = 0, posts = 0;
	always #4 aclk = ~aclk;
	tmr8_timer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .external_count_pin, .watchdog_tick, .watchdog_post_tick, .irq);
	tmr8_pin_src u_src (.aclk, .pin(external_count_pin));
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		posts <= posts + int'(watchdog_post_tick);
		if (cyc == 10000) begin
			err_count++;
			test_done();
		end
	end
	// ----
	// Bus and check tasks
	// ----
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge aclk);
		ts = cyc;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		ts = cyc;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic wd_run(input logic [7:0] opt, input int n, input int e);
		int p;
		wr(A_OPT, opt);
		wr(A_CTL, 8'h02);
		p = posts;
		repeat (n) begin
			@(posedge aclk);
			watchdog_tick <= 1'b1;
			@(posedge aclk);
			watchdog_tick <= 1'b0;
		end
		repeat (4) @(posedge aclk);
		chk("post ticks", e, posts - p);
	endtask : wd_run
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	// ----
	// Sequence
	// ----
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (ROWS[i]) begin
			wr(A_OPT, ROWS[i][32:25]);
			wr(A_CTL, {7'h0, ROWS[i][24]});
			rd(A_CNT);
			ta = ts;
			c0 = rdat;
			while (cyc < ta + int'(ROWS[i][23:8]) - 1) @(posedge aclk);
			rd(A_CNT);
			chk("count step", {24'h0, ROWS[i][7:0]}, {24'h0, rdat[7:0] - c0[7:0]});
		end
		wr(A_CNT, 8'h00);
		wd_run(8'h2F, 255, 1);
		wd_run(8'h28, 1, 1);
		wd_run(8'h27, 5, 5);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_OPT);
		chk("option reset", 32'hFF, rdat);
		rd(A_INT);
		chk("intctl reset", 32'h0, rdat);
		rd(A_CNT);
		chk("count reset", 32'h0, rdat);
		rd(12'h010);
		chk("unmapped resp", 32'h2, {30'h0, rsp});
		wr(12'h010, 8'h55);
		chk("unmapped wresp", 32'h2, {30'h0, rsp});
		for (int s = 0; s < 2; s++) begin
			wr(A_OPT, s ? 8'h38 : 8'h28);
			wr(A_CNT, 8'h00);
			u_src.step(1'b1, 0);
			rd(A_CNT);
			chk("pin early", 32'h0, rdat);
			repeat (8) @(posedge aclk);
			rd(A_CNT);
			chk("pin rise", s ? 32'h0 : 32'h1, rdat);
			u_src.step(1'b0, 8);
			rd(A_CNT);
			chk("pin fall", 32'h1, rdat);
		end
		wr(A_OPT, 8'h08);
		wr(A_CNT, 8'h40);
		tw = ts;
		rd(A_CNT);
		chk("write hold", 32'h40 + ts - tw - 4, rdat);
		wr(A_OPT, 8'h07);
		repeat (100) @(posedge aclk);
		wr(A_CNT, 8'h80);
		tw = ts;
		while (cyc < tw + 249) @(posedge aclk);
		rd(A_CNT);
		chk("prescale clear", 32'h80, rdat);
		while (cyc < tw + 279) @(posedge aclk);
		rd(A_CNT);
		chk("prescale tick", 32'h81, rdat);
		wr(A_OPT, 8'h08);
		wr(A_INT, 8'h20);
		wr(A_CNT, 8'hF8);
		repeat (20) @(posedge aclk);
		chk("irq on", 32'h1, {31'h0, irq});
		rd(A_INT);
		chk("flag set", 32'h24, rdat);
		wr(A_OPT, 8'h28);
		wr(A_INT, 8'h00);
		repeat (300) @(posedge aclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		rd(A_INT);
		chk("flag kept", 32'h04, rdat);
		wr(A_INT, 8'h20);
		repeat (2) @(posedge aclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(A_INT, 8'h24);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		test_done();
	end
endmodule : tb

// file: tb/tmr8_monitor.sv
// Purpose: Port checker for the 8-bit timer
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every timer instance
`timescale 1ns/1ps
module tmr8_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic watchdog_tick,
	input wire logic watchdog_post_tick,
	input wire logic irq
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read late");
	write_answer_a: assert property (s_axi_awready && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write late");
	resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
		else $error("bad bresp");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper bits set");
	irq_clear_a: assert property ($fell(irq) |-> s_axi_bvalid)
		else $error("irq fell alone");
	post_tick_a: assert property (watchdog_post_tick |-> $past(watchdog_tick) || $past(watchdog_tick, 2))
		else $error("stray post tick");
endmodule : tmr8_monitor
bind tmr8_timer tmr8_monitor u_mon (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.watchdog_tick, .watchdog_post_tick, .irq);

// file: tb/tmr8_pin_src.sv
// Purpose: Pulse source on the external count pin
// Assumes: Pin idles low
// Notes: Levels change just after a rising edge
`timescale 1ns/1ps
module tmr8_pin_src (
	input wire logic aclk,
	output logic pin
);
	initial pin = 1'b0;
	// Drive a level, then hold it a number of cycles
	task automatic step(input logic v, input int hold);
		@(posedge aclk);
		pin <= v;
		repeat (hold) @(posedge aclk);
	endtask : step
endmodule : tmr8_pin_src

// file: verilog/tmr8_pkg.sv
// Purpose: Constants and carriers for the 8-bit timer with shared prescaler
// Assumes: Registers reached over AXI4-Lite, one aligned word each
// Notes: Printed offsets are register indexes; byte address is four times index
package tmr8_pkg;
	// ----------------------------------------
	// Register indexes and byte addresses
	// ----------------------------------------
	localparam logic [7:0] TMR8_IDX_COUNT = 8'h01;
	localparam logic [7:0] TMR8_IDX_INTCTL = 8'h0B;
	localparam logic [7:0] TMR8_IDX_OPTION = 8'h81;
	localparam logic [7:0] TMR8_IDX_CTRL = 8'hC0;
	localparam logic [11:0] TMR8_ADDR_COUNT = {2'h0, TMR8_IDX_COUNT, 2'h0};
	localparam logic [11:0] TMR8_ADDR_INTCTL = {2'h0, TMR8_IDX_INTCTL, 2'h0};
	localparam logic [11:0] TMR8_ADDR_OPTION = {2'h0, TMR8_IDX_OPTION, 2'h0};
	localparam logic [11:0] TMR8_ADDR_CTRL = {2'h0, TMR8_IDX_CTRL, 2'h0};
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TMR8_OPT_CS = 5;
	localparam int TMR8_OPT_SE = 4;
	localparam int TMR8_OPT_PSA = 3;
	localparam int TMR8_INT_IE = 5;
	localparam int TMR8_INT_IF = 2;
	localparam int TMR8_CTRL_SLEEP = 0;
	localparam int TMR8_CTRL_CLEAR_WATCHDOG_INSTRUCTION = 1;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] TMR8_OPTION_RST = 8'hFF;
	localparam logic [7:0] TMR8_COUNT_RST = 8'h00;
	localparam logic [7:0] TMR8_INTCTL_RST = 8'h00;
	localparam logic [1:0] TMR8_WRITE_INHIBIT = 2'h2;
	localparam logic [1:0] TMR8_RESP_OKAY = 2'h0;
	localparam logic [1:0] TMR8_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic clock_source_select;
		logic source_edge_select;
		logic prescaler_assign;
		logic [2:0] prescale_ratio;
	} tmr8_cfg_s;
endpackage : tmr8_pkg

// file: verilog/tmr8_prescaler.sv
// Purpose: Shared 8-bit prescaler, timer prescaler or watchdog postscaler
// Assumes: Count value is never visible to software
// Notes: Emits one tick per selected ratio of input ticks
`timescale 1ns/1ps
module tmr8_prescaler #(
	parameter int WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick_in,
	input wire logic clear,
	input wire logic wdt_mode,
	input wire logic [2:0] ratio,
	output logic tick_out
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_next;
	logic [3:0] shift;
	logic [WIDTH-1:0] limit;

	// Timer ratios 1:2..1:256, watchdog ratios 1:1..1:128
	assign shift = wdt_mode ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1);
	assign limit = WIDTH'((9'h001 << shift) - 9'h001);
	assign cnt_next = cnt_q + WIDTH'(1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			tick_out <= 1'b0;
		end else if (clear) begin
			cnt_q <= '0;
			tick_out <= 1'b0;
		end else if (tick_in) begin
			if (cnt_q >= limit) begin
				cnt_q <= '0;
				tick_out <= 1'b1;
			end else begin
				cnt_q <= cnt_next;
				tick_out <= 1'b0;
			end
		end else begin
			tick_out <= 1'b0;
		end
	end
endmodule : tmr8_prescaler

// file: verilog/tmr8_sync.sv
// Purpose: Three-stage synchroniser with agreement filter and edge select
// Assumes: Pin input is asynchronous to aclk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module tmr8_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_in,
	input wire logic falling_sel,
	output logic edge_pulse
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;
	logic agree;
	logic rise;
	logic fall;

	assign agree = (s2_q == s3_q);
	assign rise = agree && s3_q && !level_q;
	assign fall = agree && !s3_q && level_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) begin
				level_q <= s3_q;
			end
			edge_pulse <= falling_sel ? fall : rise;
		end
	end
endmodule : tmr8_sync

// file: verilog/tmr8_timer.sv
// Purpose: 8-bit timer/counter with prescaler shared with the watchdog
// Assumes: Each aclk cycle is one instruction cycle; AXI4-Lite register access
// Notes: Watchdog counter lies outside; only its prescaler tick leaves here
`timescale 1ns/1ps
// What this block does
// - Clock source select clear: count instruction cycles, through the prescaler when it serves the timer.
// - After a counter write, counting is held off for two cycles.
// - Clock source select set: count edges of the external pin.
// - Edge select clear counts rising edges, set counts falling edges.
// - External pin is synchronised, then counted a cycle later.
// - One prescaler serves timer or watchdog, never both.
// - Software cannot read or write the prescaler count.
// - Assigned to timer, ratio field gives 1:2 up to 1:256.
// - Assigned to watchdog, ratio field gives 1:1 up to 1:128.
// - Counter writes clear the prescaler when it serves the timer.
// - Clear-watchdog clears the prescaler when it serves the watchdog.
// - Assignment may change at any time without stopping.
// - Rollover from FFh to 00h sets the overflow flag.
// - Overflow interrupt gated by the enable bit.
// - Timer stops during sleep, so overflow cannot wake.
module tmr8_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_count_pin,
	input wire logic watchdog_tick,
	output logic watchdog_post_tick,
	output logic irq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] count_q;
	logic [7:0] option_q;
	logic [7:0] intctl_q;
	logic sleep_q;
	logic [1:0] inhibit_q;
	logic aw_full_q;
	logic w_full_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	tmr8_pkg::tmr8_cfg_s cfg;

	assign cfg = '{clock_source_select: option_q[tmr8_pkg::TMR8_OPT_CS],
		source_edge_select: option_q[tmr8_pkg::TMR8_OPT_SE],
		prescaler_assign: option_q[tmr8_pkg::TMR8_OPT_PSA],
		prescale_ratio: option_q[2:0]};

	// ----------------------------------------
	// Write channel handshake
	// ----------------------------------------
	logic do_write;
	logic wr_count;
	logic wr_intctl;
	logic wr_option;
	logic wr_ctrl;
	logic wr_hit;
	logic [7:0] wbyte;
	logic wlane;

	assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wbyte = wdata_q[7:0];
	assign wlane = wstrb_q[0];
	assign wr_count = do_write && wlane && (awaddr_q == tmr8_pkg::TMR8_ADDR_COUNT);
	assign wr_intctl = do_write && wlane && (awaddr_q == tmr8_pkg::TMR8_ADDR_INTCTL);
	assign wr_option = do_write && wlane && (awaddr_q == tmr8_pkg::TMR8_ADDR_OPTION);
	assign wr_ctrl = do_write && wlane && (awaddr_q == tmr8_pkg::TMR8_ADDR_CTRL);
	assign wr_hit = (awaddr_q == tmr8_pkg::TMR8_ADDR_COUNT) || (awaddr_q == tmr8_pkg::TMR8_ADDR_INTCTL)
		|| (awaddr_q == tmr8_pkg::TMR8_ADDR_OPTION) || (awaddr_q == tmr8_pkg::TMR8_ADDR_CTRL);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tmr8_pkg::TMR8_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_full_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_full_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? tmr8_pkg::TMR8_RESP_OKAY : tmr8_pkg::TMR8_RESP_SLVERR;
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic [11:0] raddr;
	logic [7:0] rbyte;
	logic rd_hit;

	assign raddr = {s_axi_araddr[11:2], 2'h0};
	// Prescaler count has no read path
	assign rbyte = (raddr == tmr8_pkg::TMR8_ADDR_COUNT) ? count_q :
		(raddr == tmr8_pkg::TMR8_ADDR_INTCTL) ? intctl_q :
		(raddr == tmr8_pkg::TMR8_ADDR_OPTION) ? option_q :
		(raddr == tmr8_pkg::TMR8_ADDR_CTRL) ? {7'h00, sleep_q} : 8'h00;
	assign rd_hit = (raddr == tmr8_pkg::TMR8_ADDR_COUNT) || (raddr == tmr8_pkg::TMR8_ADDR_INTCTL)
		|| (raddr == tmr8_pkg::TMR8_ADDR_OPTION) || (raddr == tmr8_pkg::TMR8_ADDR_CTRL);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= tmr8_pkg::TMR8_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rbyte};
				s_axi_rresp <= rd_hit ? tmr8_pkg::TMR8_RESP_OKAY : tmr8_pkg::TMR8_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Count source and prescaler
	// ----------------------------------------
	logic pin_edge;
	logic src_tick;
	logic to_timer;
	logic ps_in;
	logic ps_clear;
	logic ps_tick;
	logic clear_watchdog_instruction;
	logic inc;

	tmr8_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(external_count_pin),
		.falling_sel(cfg.source_edge_select),
		.edge_pulse(pin_edge)
	);

	assign to_timer = !cfg.prescaler_assign;
	assign src_tick = cfg.clock_source_select ? pin_edge : 1'b1;
	assign ps_in = to_timer ? (src_tick && !sleep_q) : watchdog_tick;
	assign clear_watchdog_instruction = wr_ctrl && wbyte[tmr8_pkg::TMR8_CTRL_CLEAR_WATCHDOG_INSTRUCTION];
	// Safe reassignment sequence is software's duty
	assign ps_clear = to_timer ? wr_count : clear_watchdog_instruction;

	tmr8_prescaler #(
		.WIDTH(8)
	) u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(ps_in),
		.clear(ps_clear),
		.wdt_mode(cfg.prescaler_assign),
		.ratio(cfg.prescale_ratio),
		.tick_out(ps_tick)
	);

	// Timer without prescaler sees raw source tick
	assign inc = (to_timer ? ps_tick : src_tick) && !sleep_q && (inhibit_q == 2'h0);

	// ----------------------------------------
	// Counter, flags, configuration
	// ----------------------------------------
	logic ovf;
	logic [7:0] intctl_d;
	logic [7:0] if_bit;
	logic [7:0] ovf_bit;

	assign ovf = inc && (count_q == 8'hFF);
	assign if_bit = 8'h01 << tmr8_pkg::TMR8_INT_IF;
	assign ovf_bit = {7'h00, ovf} << tmr8_pkg::TMR8_INT_IF;
	// Flag is write-one-to-clear; overflow set wins over a clear
	assign intctl_d = wr_intctl ? ((wbyte & ~if_bit) | (intctl_q & ~wbyte & if_bit) | ovf_bit)
		: (intctl_q | ovf_bit);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= tmr8_pkg::TMR8_COUNT_RST;
			option_q <= tmr8_pkg::TMR8_OPTION_RST;
			intctl_q <= tmr8_pkg::TMR8_INTCTL_RST;
			sleep_q <= 1'b0;
			inhibit_q <= 2'h0;
			watchdog_post_tick <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wr_count) begin
				count_q <= wbyte;
				inhibit_q <= tmr8_pkg::TMR8_WRITE_INHIBIT;
			end else begin
				if (inc) begin
					count_q <= count_q + 8'h01;
				end
				if (inhibit_q != 2'h0) begin
					inhibit_q <= inhibit_q - 2'h1;
				end
			end
			if (wr_option) begin
				option_q <= wbyte;
			end
			if (wr_ctrl) begin
				sleep_q <= wbyte[tmr8_pkg::TMR8_CTRL_SLEEP];
			end
			intctl_q <= intctl_d;
			watchdog_post_tick <= cfg.prescaler_assign ? ps_tick : watchdog_tick;
			irq <= intctl_d[tmr8_pkg::TMR8_INT_IF] && intctl_d[tmr8_pkg::TMR8_INT_IE];
		end
	end
endmodule : tmr8_timer
